// >>> logic/scw_pkg.sv
`default_nettype none
package scw_pkg;

  // ***********************************************************
  // register map (byte offsets on the plain register port)
  // ***********************************************************
  localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PORT_WAKE = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_WATCHDOG = 8'h03;

  // reset values
  localparam logic [7:0] RST_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] RST_PORT_WAKE = 8'h00;
  localparam logic RST_WATCHDOG_EN = 1'b1;

  // divider codes
  localparam logic [2:0] DIV_BY_1 = 3'h0;
  localparam logic [2:0] DIV_UNDIVIDED = 3'h7;

  // field layout of system_clock_control
  typedef struct packed {
    logic [2:0] clk_div_sel;   // bits 7:5
    logic [2:0] rsvd_4_2;      // reads zero
    logic halt_osc_keep;       // bit 1
    logic rsvd_0;              // reads zero
  } scw_scc_s;

  // field layout of the status register
  typedef struct packed {
    logic [3:0] rsvd_7_4;      // reads zero
    logic in_halt;             // bit 3: sleep, idle or stabilising
    logic clk_switch_busy;     // bit 2
    logic timeout_flag;        // bit 1
    logic power_down_flag;     // bit 0
  } scw_status_s;

  // what the block does to the core when a halt ends
  typedef struct packed {
    logic full_reset;          // external reset pin wake
    logic wdt_reset;           // program counter and stack pointer only
    logic irq_service;         // normal interrupt response
    logic resume;              // continue after the halt instruction
  } scw_wake_s;

  // ***********************************************************
  // timing
  // ***********************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int STAB_TIME_NS = 10000;
  localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
  localparam int SWITCH_PERIODS = 4;
  localparam int SUB_DIV = 4;

endpackage : scw_pkg
`default_nettype wire

// >>> logic/scw_sysclk_wake.sv
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

// Contract
// R1: three-bit divider picks 1 to 64, 111 undivided
// R2: power-on clears divider and keep bit
// R3: keep bit decides oscillator runs during halt
// R4: sleep keeps substitute clock for watchdog
// R5: clock switch done within four periods plus
// R6: software waits switch delay before timed work
// R7: halt with keep zero enters sleep
// R8: halt with keep one enters idle
// R9: halt leaves memory, registers, ports untouched
// R10: halt clears watchdog counter, resumes if enabled
// R11: halt sets power-down flag, clears timeout
// R12: power-down flag cleared by power-up, clear-watchdog
// R13: wake on port edge, reset, interrupt, watchdog
// R14: pin reset full; watchdog resets counter, stack
// R15: watchdog wake sets timeout, other flags kept
// R16: per-pin wake enables; resume after halt
// R17: disabled or stack-full interrupt resumes, stays pending
// R18: enabled interrupt with room gets normal response
// R19: interrupt pending at halt cannot wake
// R20: sleep wake waits oscillator stabilisation count
module scw_sysclk_wake
  import scw_pkg::*;
#(
  parameter int PORT_W = 8,
  parameter int NIRQ = 4,
  parameter int WDT_W = 8,
  parameter int STAB_COUNT = STAB_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_halt,
  input wire logic i_clear_watchdog_instr,
  input wire logic [PORT_W-1:0] i_port_a,
  input wire logic i_ext_reset,
  input wire logic [NIRQ-1:0] i_irq_flag,
  input wire logic [NIRQ-1:0] i_irq_enable,
  input wire logic i_stack_full,
  output logic o_sys_tick,
  output logic o_high_speed_clock_on,
  output logic o_substitute_clock_on,
  output logic o_cpu_halted,
  output logic o_full_reset,
  output logic o_wdt_reset,
  output logic o_irq_service,
  output logic o_resume,
  output logic [WDT_W-1:0] o_watchdog_count
);

  // ***********************************************************
  // types and helpers
  // ***********************************************************
  typedef enum logic [3:0] {
    ST_NORMAL = 4'h1,
    ST_SLEEP = 4'h2,
    ST_IDLE = 4'h4,
    ST_STAB = 4'h8
  } scw_state_e;

  // divider tick: a code of n ticks when the low n counter bits are ones
  function automatic logic scw_div_tick(input logic [2:0] sel,
                                        input logic [5:0] cnt);
    logic t;
    t = 1'b1;
    unique case (sel)
      3'h1: t = cnt[0];
      3'h2: t = &cnt[1:0];
      3'h3: t = &cnt[2:0];
      3'h4: t = &cnt[3:0];
      3'h5: t = &cnt[4:0];
      3'h6: t = &cnt[5:0];
      default: t = 1'b1;       // 000 and 111 both pass every cycle
    endcase
    return t;
  endfunction : scw_div_tick

  localparam int SW_W = $clog2(SWITCH_PERIODS + 1);
  localparam int STAB_W = $clog2(STAB_COUNT + 1);
  localparam int SUB_W = $clog2(SUB_DIV + 1);
  localparam logic [SW_W-1:0] SW_LAST = SW_W'(SWITCH_PERIODS);
  localparam logic [STAB_W-1:0] STAB_LAST = STAB_W'(STAB_COUNT - 1);
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(SUB_DIV - 1);

  // ***********************************************************
  // state
  // ***********************************************************
  scw_state_e state;                 // power mode
  scw_scc_s system_clock_control;                     // software view of clock control
  logic [2:0] cur_sel;               // divider code in effect
  logic sw_busy;                     // switch to scc.clk_div_sel pending
  logic [SW_W-1:0] sw_cnt;           // current periods since the write
  logic [5:0] div_cnt;               // divider counter
  logic [PORT_W-1:0] port_wake_enable;
  logic [PORT_W-1:0] port_prev;      // port value a cycle ago
  logic [NIRQ-1:0] irq_at_halt;      // flags already set at halt entry
  logic power_down_flag;
  logic timeout_flag;
  logic watchdog_en;                 // watchdog function enable
  logic [WDT_W-1:0] wdt_cnt;         // watchdog counter
  logic [SUB_W-1:0] sub_cnt;         // substitute clock prescaler
  logic [STAB_W-1:0] stab_cnt;       // stabilisation counter
  scw_wake_s wake_act;               // action held across stabilising

  // ***********************************************************
  // decode
  // ***********************************************************
  logic halted;
  logic div_tick;
  logic sub_on;
  logic sub_tick;
  logic wdt_ovf;
  logic port_edge;
  logic irq_wake;
  logic irq_ok;
  logic halt_go;
  logic wake_any;
  scw_wake_s next_wake;
  scw_scc_s wr_scc;

  assign wr_scc = scw_scc_s'(i_wdata);
  assign halted = (state != ST_NORMAL);
  // only normal mode accepts the halt strobe
  assign halt_go = i_halt && (state == ST_NORMAL);
  // the divider stops with the oscillator in sleep
  assign div_tick = (state != ST_SLEEP) && (state != ST_STAB)
                    && scw_div_tick(cur_sel, div_cnt);  // [R1]
  // substitute clock runs except in sleep with watchdog off
  assign sub_on = (state != ST_SLEEP) || watchdog_en;   // [R4]
  assign sub_tick = sub_on && (sub_cnt == SUB_LAST);
  assign wdt_ovf = watchdog_en && sub_tick && (&wdt_cnt);
  // falling edge on a pin whose wake bit is set
  assign port_edge = |(port_prev & ~i_port_a
                       & port_wake_enable);             // [R16]
  // interrupts pending at halt entry lose their wake power
  assign irq_wake = |(i_irq_flag & ~irq_at_halt);       // [R19]
  assign irq_ok = |(i_irq_flag & ~irq_at_halt & i_irq_enable)
                  && !i_stack_full;                     // [R17] [R18]
  assign wake_any = (state == ST_SLEEP || state == ST_IDLE)
                    && (i_ext_reset || wdt_ovf || irq_wake
                        || port_edge);                  // [R13]

  // wake action, highest priority first
  always_comb begin
    next_wake = '0;
    if (i_ext_reset) begin
      next_wake.full_reset = 1'b1;                      // [R14]
    end else if (wdt_ovf) begin
      next_wake.wdt_reset = 1'b1;                       // [R14]
    end else if (irq_wake && irq_ok) begin
      next_wake.irq_service = 1'b1;                     // [R18]
    end else begin
      // port edge, or an interrupt that must stay pending
      next_wake.resume = 1'b1;                          // [R16] [R17]
    end
  end

  // ***********************************************************
  // power mode sequencer
  // ***********************************************************
  // memory, core registers and ports are never touched here: the
  // block only gates clocks and reports, so all state is kept [R9]
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state <= ST_NORMAL;
    end else if (i_ce) begin
      unique case (state)
        ST_NORMAL: begin
          if (halt_go && system_clock_control.halt_osc_keep) begin
            state <= ST_IDLE;                           // [R8]
          end else if (halt_go) begin
            state <= ST_SLEEP;                          // [R7]
          end
        end
        ST_SLEEP: begin
          // oscillator restarts, so wait it out [R20]
          if (wake_any) begin
            state <= ST_STAB;
          end
        end
        ST_IDLE: begin
          if (wake_any) begin
            state <= ST_NORMAL;
          end
        end
        ST_STAB: begin
          if (stab_cnt == STAB_LAST) begin
            state <= ST_NORMAL;                         // [R20]
          end
        end
      endcase
    end
  end

  // stabilisation count and the held wake action
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      stab_cnt <= '0;
      wake_act <= '0;
    end else if (i_ce) begin
      if (wake_any) begin
        wake_act <= next_wake;
        stab_cnt <= '0;
      end else if (state == ST_STAB) begin
        stab_cnt <= stab_cnt + STAB_W'(1);
      end
    end
  end

  // one-cycle action pulses as the core restarts
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_full_reset <= 1'b0;
      o_wdt_reset <= 1'b0;
      o_irq_service <= 1'b0;
      o_resume <= 1'b0;
    end else if (i_ce) begin
      o_full_reset <= 1'b0;
      o_wdt_reset <= 1'b0;
      o_irq_service <= 1'b0;
      o_resume <= 1'b0;
      if (state == ST_IDLE && wake_any) begin
        o_full_reset <= next_wake.full_reset;           // [R14]
        o_wdt_reset <= next_wake.wdt_reset;             // [R14]
        o_irq_service <= next_wake.irq_service;         // [R18]
        o_resume <= next_wake.resume;                   // [R16]
      end else if (state == ST_STAB && stab_cnt == STAB_LAST) begin
        o_full_reset <= wake_act.full_reset;            // [R20]
        o_wdt_reset <= wake_act.wdt_reset;
        o_irq_service <= wake_act.irq_service;
        o_resume <= wake_act.resume;
      end else if (state == ST_NORMAL && wdt_ovf) begin
        // a timeout while running resets the whole device
        o_full_reset <= 1'b1;
      end
    end
  end

  // snapshot of pending interrupts at halt entry
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      irq_at_halt <= '0;
    end else if (i_ce) begin
      if (halt_go) begin
        irq_at_halt <= i_irq_flag;                      // [R19]
      end else if (state == ST_NORMAL) begin
        irq_at_halt <= '0;
      end
    end
  end

  // port history for edge detection
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      port_prev <= '0;
    end else if (i_ce) begin
      port_prev <= i_port_a;
    end
  end

  // ***********************************************************
  // clock divider and switching
  // ***********************************************************
  // the new code waits four current periods, then takes effect at
  // the next current tick with the counter restarted, so the first
  // target period starts clean; no glitch reaches the core [R5]
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      cur_sel <= DIV_BY_1;                              // [R2]
      sw_busy <= 1'b0;
      sw_cnt <= '0;
      div_cnt <= '0;
    end else if (i_ce) begin
      if (div_tick && sw_busy && sw_cnt == SW_LAST) begin
        cur_sel <= system_clock_control.clk_div_sel;                     // [R5]
        sw_busy <= 1'b0;
        div_cnt <= '0;
      end else if (state != ST_SLEEP && state != ST_STAB) begin
        div_cnt <= div_cnt + 6'h01;
        if (div_tick && sw_busy) begin
          sw_cnt <= sw_cnt + SW_W'(1);
        end
      end
      // a fresh write restarts the wait
      if (i_wr && i_addr == ADDR_CLOCK_CONTROL) begin
        sw_busy <= (wr_scc.clk_div_sel != cur_sel);     // [R5]
        sw_cnt <= '0;
      end
    end
  end

  // ***********************************************************
  // watchdog counter
  // ***********************************************************
  // cleared by halt, by the clear instruction and on overflow; it
  // only advances while enabled, so after a halt it stays stopped
  // when the function is off [R10]
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wdt_cnt <= '0;
      sub_cnt <= '0;
    end else if (i_ce) begin
      if (sub_on) begin
        sub_cnt <= sub_tick ? '0 : sub_cnt + SUB_W'(1);
      end
      if (halt_go || i_clear_watchdog_instr || wdt_ovf) begin
        wdt_cnt <= '0;                                  // [R10]
      end else if (watchdog_en && sub_tick) begin
        wdt_cnt <= wdt_cnt + WDT_W'(1);
      end
    end
  end

  // ***********************************************************
  // status flags
  // ***********************************************************
  // set wins over clear in both flags
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      power_down_flag <= 1'b0;                          // [R12]
      timeout_flag <= 1'b0;
    end else if (i_ce) begin
      if (halt_go) begin
        power_down_flag <= 1'b1;                        // [R11]
      end else if (i_clear_watchdog_instr) begin
        power_down_flag <= 1'b0;                        // [R12]
      end
      if (wdt_ovf) begin
        timeout_flag <= 1'b1;                           // [R15]
      end else if (halt_go) begin
        timeout_flag <= 1'b0;                           // [R11]
      end
    end
  end

  // ***********************************************************
  // software registers
  // ***********************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      system_clock_control <= scw_scc_s'(RST_CLOCK_CONTROL);             // [R2]
      port_wake_enable <= PORT_W'(RST_PORT_WAKE);
      watchdog_en <= RST_WATCHDOG_EN;
    end else if (i_ce && i_wr) begin
      unique case (i_addr)
        ADDR_CLOCK_CONTROL: begin
          system_clock_control.clk_div_sel <= wr_scc.clk_div_sel;        // [R1]
          system_clock_control.halt_osc_keep <= wr_scc.halt_osc_keep;    // [R3]
        end
        ADDR_PORT_WAKE: begin
          port_wake_enable <= i_wdata[PORT_W-1:0];      // [R16]
        end
        ADDR_WATCHDOG: begin
          watchdog_en <= i_wdata[0];
        end
        default: begin
        end
      endcase
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= 8'h00;
      if (i_rd) begin
        unique case (i_addr)
          ADDR_CLOCK_CONTROL: begin
            // unimplemented bits read back as zero [R2]
            o_rdata <= {system_clock_control.clk_div_sel, 3'h0, system_clock_control.halt_osc_keep, 1'b0};
          end
          ADDR_PORT_WAKE: begin
            o_rdata <= 8'(port_wake_enable);
          end
          ADDR_STATUS: begin
            // busy lets software wait out the switch [R6]
            o_rdata <= {4'h0, halted, sw_busy, timeout_flag,
                        power_down_flag};
          end
          ADDR_WATCHDOG: begin
            o_rdata <= {7'h00, watchdog_en};
          end
          default: begin
            o_rdata <= 8'h00;
          end
        endcase
      end
    end
  end

  // ***********************************************************
  // clock gating outputs
  // ***********************************************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_sys_tick <= 1'b0;
      o_high_speed_clock_on <= 1'b1;
      o_substitute_clock_on <= 1'b1;
      o_cpu_halted <= 1'b0;
      o_watchdog_count <= '0;
    end else if (i_ce) begin
      // idle keeps the system clock; a sleep halt stops it [R7] [R8]
      o_sys_tick <= div_tick && !(halt_go && !system_clock_control.halt_osc_keep);
      o_high_speed_clock_on <= (state != ST_SLEEP)
                               && (state != ST_STAB);   // [R3]
      o_substitute_clock_on <= sub_on;                  // [R4]
      o_cpu_halted <= halted || halt_go;
      o_watchdog_count <= wdt_cnt;
    end
  end

endmodule : scw_sysclk_wake
`default_nettype wire

// >>> testbench/scw_sysclk_wake_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ***
// halt and wake checker, top ports only
// ***
module scw_sysclk_wake_assertions
  import scw_pkg::*;
#(
  parameter int WDT_W = 8
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_halt,
  input wire logic i_ext_reset,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] o_rdata,
  input wire logic o_sys_tick,
  input wire logic o_high_speed_clock_on,
  input wire logic o_substitute_clock_on,
  input wire logic o_cpu_halted,
  input wire logic o_full_reset,
  input wire logic o_wdt_reset,
  input wire logic o_irq_service,
  input wire logic o_resume,
  input wire logic [WDT_W-1:0] o_watchdog_count
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // wake actions that only a halt can end in
  logic wake_any;
  assign wake_any = o_wdt_reset | o_irq_service | o_resume;
  // a halt while running, then halted with the watchdog copy at zero
  sequence s_taken; i_halt && !o_cpu_halted; endsequence
  sequence s_entered; o_cpu_halted ##1 (o_watchdog_count == '0); endsequence
  property p_enter; s_taken |=> s_entered; endproperty
  a_enter: assert property (p_enter)
    else $error("halt entry wrong");
  property p_cause; $rose(o_cpu_halted) |-> $past(i_halt); endproperty
  a_cause: assert property (p_cause)
    else $error("halted without a halt");
  property p_no_tick; !o_high_speed_clock_on |-> !o_sys_tick; endproperty
  a_no_tick: assert property (p_no_tick)
    else $error("tick while fast clock off");
  // fast clock may only stop while the core is off
  property p_hs_off; !o_high_speed_clock_on |-> o_cpu_halted; endproperty
  a_hs_off: assert property (p_hs_off)
    else $error("fast clock off while running");
  property p_sub_off;
    !o_substitute_clock_on |-> !o_high_speed_clock_on;
  endproperty
  a_sub_off: assert property (p_sub_off)
    else $error("slow clock off outside sleep");
  property p_onehot;
    $onehot0({o_full_reset, o_wdt_reset, o_irq_service, o_resume});
  endproperty
  a_onehot: assert property (p_onehot)
    else $error("two wake actions at once");
  property p_wake_halted; wake_any |-> o_cpu_halted; endproperty
  a_wake_halted: assert property (p_wake_halted)
    else $error("wake action while running");
  property p_ext_wake;
    o_cpu_halted && o_high_speed_clock_on && i_ext_reset && !wake_any
      && !o_full_reset |-> ##[1:2] o_full_reset;
  endproperty
  a_ext_wake: assert property (p_ext_wake)
    else $error("reset pin did not wake");
  // unimplemented control bits read zero
  property p_rsvd;
    $past(i_rd) && ($past(i_addr) == ADDR_CLOCK_CONTROL)
      |-> (o_rdata[4:2] == 3'h0) && !o_rdata[0];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved control bits set");
endmodule : scw_sysclk_wake_assertions
`default_nettype wire

// >>> testbench/scw_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***
// core model: executes halt, notes how it woke
// ***
module scw_core_model
  import scw_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic i_cpu_halted,
  input wire scw_wake_s i_wake,
  output logic o_halt,
  output var scw_wake_s o_last,
  output var int o_wakes
);
  // one-cycle halt, only while running: a stopped core fetches nothing
  always_ff @(posedge i_clock) begin
    if (i_rst) o_halt <= 1'b0;
    else o_halt <= i_go && !i_cpu_halted && !o_halt;
  end
  // keep the last wake action and a count for the bench
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_last <= '0;
      o_wakes <= 0;
    end else if (i_wake != '0) begin
      o_last <= i_wake;
      o_wakes <= o_wakes + 1;
    end
  end
endmodule : scw_core_model
`default_nettype wire

// >>> testbench/tb_scw_sysclk_wake.sv
`timescale 1ns/100ps
`default_nettype none
module tb_scw_sysclk_wake import scw_pkg::*;;
  // ***
  // stimulus and design
  // ***
  localparam int WDT_W = 3; // short watchdog keeps the run brief
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
  } scw_row_s;
  // write then read back: read-only status, unmapped, reserved bits
  localparam scw_row_s ROWS [6] = '{'{8'h03, 8'h00, 8'h00},
    '{8'h02, 8'hFF, 8'h00}, '{8'h01, 8'hA5, 8'hA5},
    '{8'h07, 8'hFF, 8'h00}, '{8'h00, 8'hFF, 8'hE2}, '{8'h00, 8'h00, 8'h00}};
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_clear_watchdog_instr = 1'b0;
  logic [7:0] i_port_a = 8'hFF; // idle high, wake on a fall
  logic i_ext_reset = 1'b0;
  logic [3:0] i_irq_flag = 4'h0;
  logic [3:0] i_irq_enable = 4'h0;
  logic i_stack_full = 1'b0;
  logic go = 1'b0;
  logic halt;
  logic [7:0] o_rdata;
  logic o_sys_tick, o_high_speed_clock_on, o_substitute_clock_on;
  logic o_cpu_halted, o_full_reset, o_wdt_reset, o_irq_service, o_resume;
  logic [WDT_W-1:0] o_watchdog_count;
  scw_wake_s wake;
  scw_wake_s last;
  int wakes;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  int p;
  assign wake = {o_full_reset, o_wdt_reset, o_irq_service, o_resume};
  always #5 i_clock = ~i_clock;
  scw_sysclk_wake #(.WDT_W(WDT_W), .STAB_COUNT(4)) scw_sysclk_wake_i (
    .i_clock(i_clock), .i_rst(i_rst), .i_ce(1'b1), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_halt(halt), .i_clear_watchdog_instr(i_clear_watchdog_instr),
    .i_port_a(i_port_a), .i_ext_reset(i_ext_reset),
    .i_irq_flag(i_irq_flag), .i_irq_enable(i_irq_enable),
    .i_stack_full(i_stack_full), .o_sys_tick(o_sys_tick),
    .o_high_speed_clock_on(o_high_speed_clock_on),
    .o_substitute_clock_on(o_substitute_clock_on),
    .o_cpu_halted(o_cpu_halted), .o_full_reset(o_full_reset),
    .o_wdt_reset(o_wdt_reset), .o_irq_service(o_irq_service),
    .o_resume(o_resume), .o_watchdog_count(o_watchdog_count));
  scw_core_model scw_core_model_i (.i_clock(i_clock), .i_rst(i_rst),
    .i_go(go), .i_cpu_halted(o_cpu_halted), .i_wake(wake),
    .o_halt(halt), .o_last(last), .o_wakes(wakes));
  // ***
  // helpers
  // ***
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_t(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("unexpected at %0t: took %0d cycles", $time, got);
    end
  endtask : chk_t
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask : wait_n
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, e);
  endtask : rd_chk
  task automatic do_halt();
    @(posedge i_clock);
    go <= 1'b1;
    @(posedge i_clock);
    go <= 1'b0;
    wait_n(3);
  endtask : do_halt
  task automatic no_wake();
    int w0;
    w0 = wakes;
    wait_n(12);
    chk_t(wakes - w0, 0, 0);
  endtask : no_wake
  // bounded wait for the core model to note a wake
  task automatic wake_chk(input logic [3:0] e, input int lo, input int hi);
    int n;
    int w0;
    n = 0;
    w0 = wakes;
    while (wakes == w0 && n < 100) begin
      wait_n(1);
      n++;
    end
    chk_t(n, lo, hi);
    chk({4'h0, last}, {4'h0, e});
  endtask : wake_chk
  task automatic results();
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // hang guard, well above the few thousand cycles needed
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  // ***
  // tests
  // ***
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    foreach (ROWS[k]) begin
      wr(ROWS[k].addr, ROWS[k].wdata);
      rd_chk(ROWS[k].addr, ROWS[k].rdata);
    end
    // every divider code, ending back at divide by one
    for (int k = 1; k <= 8; k++) begin
      wr(8'h00, {3'(k), 5'h00});
      rd_chk(8'h02, 8'h04);
      wait_n(400);
      rd_chk(8'h02, 8'h00);
      while (o_sys_tick !== 1'b1 && p < 300) begin
        wait_n(1);
        p++;
      end
      p = 0;
      do begin
        wait_n(1);
        p++;
      end while (o_sys_tick !== 1'b1 && p < 300);
      chk_t(p, 1 << ((k & 7) % 7), 1 << ((k & 7) % 7));
      p = 0;
    end
    // idle, wake only by an enabled pin
    wr(8'h00, 8'h02);
    wr(8'h01, 8'h01);
    do_halt();
    chk({4'h0, o_sys_tick, o_cpu_halted, o_high_speed_clock_on,
      o_substitute_clock_on}, 8'h0F);
    rd_chk(8'h02, 8'h09);
    @(posedge i_clock);
    i_port_a <= 8'hFD;
    no_wake();
    @(posedge i_clock);
    i_port_a <= 8'hFC;
    wake_chk(4'h1, 1, 5);
    @(posedge i_clock);
    i_port_a <= 8'hFF;
    rd_chk(8'h02, 8'h01);
    @(posedge i_clock);
    i_clear_watchdog_instr <= 1'b1;
    @(posedge i_clock);
    i_clear_watchdog_instr <= 1'b0;
    rd_chk(8'h02, 8'h00);
    // sleep, watchdog off, serviced interrupt after stabilising
    wr(8'h00, 8'h00);
    do_halt();
    chk({4'h0, o_sys_tick, o_cpu_halted, o_high_speed_clock_on,
      o_substitute_clock_on}, 8'h04);
    @(posedge i_clock);
    i_irq_enable <= 4'h1;
    i_irq_flag <= 4'h1;
    wake_chk(4'h2, 5, 10);
    // flag pending at entry is ignored; stack full only resumes
    wr(8'h00, 8'h02);
    i_irq_flag <= 4'h2;
    do_halt();
    no_wake();
    @(posedge i_clock);
    i_irq_enable <= 4'h4;
    i_stack_full <= 1'b1;
    i_irq_flag <= 4'h6;
    wake_chk(4'h1, 1, 5);
    @(posedge i_clock);
    i_irq_flag <= 4'h0;
    i_stack_full <= 1'b0;
    // sleep with watchdog on: slow clock runs, overflow wakes
    wr(8'h00, 8'h00);
    wr(8'h03, 8'h01);
    do_halt();
    chk({7'h0, o_substitute_clock_on}, 8'h01);
    wake_chk(4'h4, 20, 60);
    rd_chk(8'h02, 8'h03);
    wr(8'h03, 8'h00);
    // idle, reset pin wake; halt cleared the timeout flag
    wr(8'h00, 8'h02);
    do_halt();
    @(posedge i_clock);
    i_ext_reset <= 1'b1;
    @(posedge i_clock);
    i_ext_reset <= 1'b0;
    wake_chk(4'h8, 1, 4);
    rd_chk(8'h02, 8'h01);
    // power-on reset clears fields and the power-down flag
    wr(8'h00, 8'h22);
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    rd_chk(8'h03, 8'h01);
    wr(8'h03, 8'h00);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h02, 8'h00);
    results();
  end
endmodule : tb_scw_sysclk_wake
bind scw_sysclk_wake scw_sysclk_wake_assertions #(.WDT_W(WDT_W)) chk_i (
  .i_clock(i_clock), .i_rst(i_rst), .i_halt(i_halt),
  .i_ext_reset(i_ext_reset), .i_rd(i_rd), .i_addr(i_addr),
  .o_rdata(o_rdata), .o_sys_tick(o_sys_tick),
  .o_high_speed_clock_on(o_high_speed_clock_on),
  .o_substitute_clock_on(o_substitute_clock_on),
  .o_cpu_halted(o_cpu_halted), .o_full_reset(o_full_reset),
  .o_wdt_reset(o_wdt_reset), .o_irq_service(o_irq_service),
  .o_resume(o_resume), .o_watchdog_count(o_watchdog_count));
`default_nettype wire
